// *** hw/autoneg_pkg.sv ***
/*
 * Shared constants for the negotiation configuration and control block:
 * management offsets, field positions, reset values, code word layout,
 * timing figures and the sequencer state type.
 * Assumes a 250 MHz system clock and 16-bit management registers.
 */
package autoneg_pkg;

	// management register offsets
	localparam logic [4:0] REG_BASIC_MODE_CONTROL = 5'h00;
	localparam logic [4:0] REG_BASIC_MODE_STATUS = 5'h01;
	localparam logic [4:0] REG_NEGOTIATION_ADVERTISEMENT = 5'h04;
	localparam logic [4:0] REG_PARTNER_ABILITY = 5'h05;
	localparam logic [4:0] REG_NEGOTIATION_EXPANSION = 5'h06;
	localparam logic [4:0] REG_PHY_LINK_STATUS = 5'h10;

	// basic mode control fields
	localparam int CTRL_SPEED_BIT = 13;
	localparam int CTRL_NEG_ENABLE_BIT = 12;
	localparam int CTRL_RESTART_BIT = 9;
	localparam int CTRL_DUPLEX_BIT = 8;

	// basic mode status: fixed ability bits plus live bits
	localparam logic [15:0] STATUS_FIXED = 16'h7849;
	localparam int STATUS_COMPLETE_BIT = 5;
	localparam int STATUS_REMOTE_FAULT_BIT = 4;
	localparam int STATUS_LINK_BIT = 2;

	// ability field [8:5]: bit0 10 half, bit1 10 full, bit2 100 half,
	// bit3 100 full
	localparam int ADV_LSB = 5;
	localparam int ADV_MSB = 8;
	localparam logic [3:0] ADV_RESET = 4'hf;
	localparam logic [4:0] SELECTOR_IEEE = 5'h01;

	// link code word layout
	localparam int CW_NEXT_PAGE_BIT = 15;
	localparam int CW_ACK_BIT = 14;
	localparam int CW_REMOTE_FAULT_BIT = 13;

	// partner ability after parallel detection
	localparam logic [15:0] PARTNER_PD_100 = 16'h0081;
	localparam logic [15:0] PARTNER_PD_10 = 16'h0021;

	// expansion register fields
	localparam int EXP_PD_FAULT_BIT = 4;
	localparam int EXP_LP_NP_BIT = 3;
	localparam int EXP_NP_ABLE_BIT = 2;
	localparam int EXP_PAGE_RX_BIT = 1;
	localparam int EXP_LP_AN_BIT = 0;

	// phy link status fields
	localparam int PHYST_COMPLETE_BIT = 4;
	localparam int PHYST_DUPLEX_BIT = 2;
	localparam int PHYST_SPEED10_BIT = 1;
	localparam int PHYST_LINK_BIT = 0;

	// timing
	localparam int CLK_FREQ_HZ = 250000000;
	localparam int MS_PER_S = 1000;
	localparam int MS_TICK_CYCLES = CLK_FREQ_HZ / MS_PER_S;
	localparam int BREAK_LINK_MS = 1500;
	localparam int BURST_INTERVAL_MS = 16;

	typedef enum logic [2:0] {
		ST_DISABLED = 3'b000,
		ST_BREAK = 3'b001,
		ST_ABILITY = 3'b011,
		ST_ACK = 3'b010,
		ST_GOOD = 3'b110
	} an_state_t;

endpackage

// *** hw/resolve_if.sv ***
/*
 * Carrier between the sequencer and the ability resolver: the local and
 * partner ability sets and the chosen mode.
 * Assumes both ends sit in the same clock domain; it is purely wires.
 */
`timescale 1ns/1ps
interface resolve_if;
	logic [3:0] local_abl;
	logic [3:0] partner_abl;
	logic valid;
	logic speed_100;
	logic full_duplex;

	modport resolver (
		input local_abl,
		input partner_abl,
		output valid,
		output speed_100,
		output full_duplex
	);
	modport user (
		output local_abl,
		output partner_abl,
		input valid,
		input speed_100,
		input full_duplex
	);
endinterface

// *** hw/ability_resolver.sv ***
/*
 * Picks the highest common ability of two ability sets.
 * Assumes the caller registers the result; this is combinational only.
 */
`timescale 1ns/1ps
module ability_resolver (
	resolve_if.resolver rif
);
	logic [3:0] common;

	assign common = rif.local_abl & rif.partner_abl;

	always_comb begin
		rif.valid = 1'b1;
		rif.speed_100 = 1'b0;
		rif.full_duplex = 1'b0;
		if (common[3]) begin
			rif.speed_100 = 1'b1;
			rif.full_duplex = 1'b1;
		end else if (common[2]) begin
			rif.speed_100 = 1'b1;
		end else if (common[1]) begin
			rif.full_duplex = 1'b1;
		end else if (!common[0]) begin
			rif.valid = 1'b0; // nothing shared
		end
	end
endmodule

// *** hw/autoneg_config_control.sv ***
/*
 * Negotiation configuration and control for a 10/100 twisted pair port:
 * strap capture, forced modes, ability exchange sequencing, parallel
 * detection and the management register file.
 * Assumes the link front end decodes received code words and reports
 * 10 and 100 link integrity; straps are stable around reset release.
 */
// Function
// - straps captured at reset release into advertised ability bits 8:5
// - enable strap low forces one of four speed/duplex modes
// - enable strap high picks the advertised ability set
// - control register writes override strap choice; enabling after forced straps needs a prior clear
// - advertised word is sent in bursts while negotiating
// - highest common mode chosen, 100 full first, 10 half last
// - control register enables, disables and restarts negotiation
// - forced mode uses control speed and duplex bits
// - speed and duplex bits ignored while negotiation enabled
// - link status register shows resolved speed once linked
// - status ability bits are constants, T4 reads zero
// - status shows complete, remote fault, link and preamble support
// - advertisement defaults to the strap ability set; cleared bits restrict
// - partner base and next page words kept in partner register
// - parallel detection loads partner register 0081 or 0021
// - expansion shows pd fault, np support, page received, lp able
// - writing control bit 9 restarts negotiation
// - renegotiation goes quiet for break link time then bursts
`timescale 1ns/1ps
module autoneg_config_control #(
	parameter int MS_TICK_CYCLES = autoneg_pkg::MS_TICK_CYCLES,
	parameter int BREAK_LINK_MS = autoneg_pkg::BREAK_LINK_MS,
	parameter int BURST_INTERVAL_MS = autoneg_pkg::BURST_INTERVAL_MS
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_negotiate_enable_strap,
	input wire logic i_mode_strap_high,
	input wire logic i_mode_strap_low,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [4:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_rx_word_valid,
	input wire logic [15:0] i_rx_word,
	input wire logic i_flp_seen,
	input wire logic i_link_100_ok,
	input wire logic i_link_10_ok,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic [15:0] o_tx_word,
	output logic o_tx_burst,
	output logic o_tx_quiet,
	output logic o_link_up,
	output logic o_speed_100,
	output logic o_full_duplex,
	output logic o_an_complete
);
	localparam int TICK_W = $clog2(MS_TICK_CYCLES);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_TICK_CYCLES - 1);
	localparam logic [10:0] BREAK_LAST = 11'(BREAK_LINK_MS - 1);
	localparam logic [10:0] BURST_LAST = 11'(BURST_INTERVAL_MS - 1);

	generate
		if (MS_TICK_CYCLES < 2 || BREAK_LINK_MS < 1 || BREAK_LINK_MS > 2047
			|| BURST_INTERVAL_MS < 1 || BURST_INTERVAL_MS > 2047) begin : g_bad
			$error("autoneg_config_control: timer parameter out of range");
		end
	endgenerate

	// ability set for a strap pattern while negotiating
	function automatic logic [3:0] strap_adv(input logic hi, input logic lo);
		case ({hi, lo})
			2'b00: strap_adv = 4'h3;
			2'b01: strap_adv = 4'hc;
			2'b10: strap_adv = 4'h5;
			default: strap_adv = 4'hf;
		endcase
	endfunction

	// single ability bit for one speed/duplex pair
	function automatic logic [3:0] mode_abl(input logic spd, input logic dup);
		mode_abl = 4'h1 << {spd, dup};
	endfunction

	logic strap_taken;
	logic ctrl_speed;
	logic ctrl_neg_en;
	logic ctrl_duplex;
	logic neg_armed;
	logic [3:0] adv;
	logic [15:0] partner;
	logic pd_fault;
	logic page_rx;
	logic lp_np_able;
	logic lp_an_able;
	logic [TICK_W-1:0] tick_cnt;
	logic ms_tick;
	logic [10:0] wait_cnt;
	logic res_speed;
	logic res_duplex;
	autoneg_pkg::an_state_t state;
	autoneg_pkg::an_state_t next_state;
	logic neg_active;
	logic restart;
	logic wr_ctrl;
	logic wr_adv;
	logic rd_exp;
	logic pd_single;
	logic pd_both;
	logic rx_ack;
	logic link_ok;
	logic op_speed;
	logic op_duplex;
	logic [15:0] next_rdata;

	resolve_if rif ();

	ability_resolver u_resolver (
		.rif(rif.resolver)
	);

	assign rif.local_abl = adv;
	assign rif.partner_abl = i_rx_word[autoneg_pkg::ADV_MSB:autoneg_pkg::ADV_LSB];

	assign wr_ctrl = strap_taken && i_reg_wr
		&& i_reg_addr == autoneg_pkg::REG_BASIC_MODE_CONTROL;
	assign wr_adv = strap_taken && i_reg_wr
		&& i_reg_addr == autoneg_pkg::REG_NEGOTIATION_ADVERTISEMENT;
	assign rd_exp = i_reg_rd
		&& i_reg_addr == autoneg_pkg::REG_NEGOTIATION_EXPANSION;
	assign restart = wr_ctrl && i_reg_wdata[autoneg_pkg::CTRL_RESTART_BIT];
	// forced start needs a clear before a set counts
	assign neg_active = ctrl_neg_en && neg_armed;
	assign pd_single = (i_link_100_ok ^ i_link_10_ok) && !i_flp_seen;
	assign pd_both = i_link_100_ok && i_link_10_ok && !i_flp_seen;
	assign rx_ack = i_rx_word_valid && i_rx_word[autoneg_pkg::CW_ACK_BIT];

	// control bits pick the forced mode
	assign op_speed = neg_active ? res_speed : ctrl_speed;
	assign op_duplex = neg_active ? res_duplex : ctrl_duplex;
	assign link_ok = op_speed ? i_link_100_ok : i_link_10_ok;

	// one millisecond tick divider feeds the standard timers
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= tick_cnt == TICK_LAST;
			tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
		end
	end

	// straps are caught on the first edge after reset release
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			strap_taken <= 1'b0;
		end else begin
			strap_taken <= 1'b1;
		end
	end

	// control register; strap value first, then software
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_speed <= 1'b0;
			ctrl_neg_en <= 1'b0;
			ctrl_duplex <= 1'b0;
			neg_armed <= 1'b0;
		end else if (!strap_taken) begin
			ctrl_neg_en <= i_negotiate_enable_strap;
			ctrl_speed <= i_mode_strap_high;
			ctrl_duplex <= i_mode_strap_low;
			neg_armed <= i_negotiate_enable_strap;
		end else if (wr_ctrl) begin
			ctrl_speed <= i_reg_wdata[autoneg_pkg::CTRL_SPEED_BIT];
			ctrl_neg_en <= i_reg_wdata[autoneg_pkg::CTRL_NEG_ENABLE_BIT];
			ctrl_duplex <= i_reg_wdata[autoneg_pkg::CTRL_DUPLEX_BIT];
			// a write of zero arms later enables
			if (!i_reg_wdata[autoneg_pkg::CTRL_NEG_ENABLE_BIT]) begin
				neg_armed <= 1'b1;
			end
		end
	end

	// advertisement register abilities
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			// all abilities until straps are seen
			adv <= autoneg_pkg::ADV_RESET;
		end else if (!strap_taken) begin
			// enable strap selects the ability set
			adv <= i_negotiate_enable_strap
				? strap_adv(i_mode_strap_high, i_mode_strap_low)
				: mode_abl(i_mode_strap_high, i_mode_strap_low);
		end else if (wr_adv) begin
			adv <= i_reg_wdata[autoneg_pkg::ADV_MSB:autoneg_pkg::ADV_LSB];
		end
	end

	// sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			autoneg_pkg::ST_DISABLED: begin
				if (neg_active) begin
					next_state = autoneg_pkg::ST_BREAK;
				end
			end
			autoneg_pkg::ST_BREAK: begin
				if (ms_tick && wait_cnt == '0) begin
					next_state = autoneg_pkg::ST_ABILITY;
				end
			end
			autoneg_pkg::ST_ABILITY: begin
				if (i_rx_word_valid) begin
					next_state = autoneg_pkg::ST_ACK;
				end else if (pd_single) begin
					next_state = autoneg_pkg::ST_GOOD;
				end
			end
			autoneg_pkg::ST_ACK: begin
				if (rx_ack) begin
					next_state = autoneg_pkg::ST_GOOD;
				end
			end
			autoneg_pkg::ST_GOOD: begin
				// lost link resumes the exchange
				if (!link_ok) begin
					next_state = autoneg_pkg::ST_ABILITY;
				end
			end
			default: next_state = autoneg_pkg::ST_DISABLED;
		endcase
		if (!neg_active) begin
			next_state = autoneg_pkg::ST_DISABLED;
		end else if (restart) begin
			// a restart from any state breaks the link first
			next_state = autoneg_pkg::ST_BREAK;
		end
	end

	// sequencer state and millisecond wait counter
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= autoneg_pkg::ST_DISABLED;
			wait_cnt <= '0;
		end else begin
			state <= next_state;
			if (next_state == autoneg_pkg::ST_BREAK
				&& (state != autoneg_pkg::ST_BREAK || restart)) begin
				wait_cnt <= BREAK_LAST;
			end else if (ms_tick) begin
				wait_cnt <= (wait_cnt == '0) ? BURST_LAST : wait_cnt - 1'b1;
			end
		end
	end

	// resolved mode, latched when the exchange finishes or parallel detection succeeds
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			res_speed <= 1'b0;
			res_duplex <= 1'b0;
		end else if (state == autoneg_pkg::ST_ACK && rx_ack) begin
			res_speed <= rif.speed_100 && rif.valid;
			res_duplex <= rif.full_duplex && rif.valid;
		end else if (state == autoneg_pkg::ST_ABILITY && !i_rx_word_valid
			&& pd_single) begin
			// parallel detection is always half duplex
			res_speed <= i_link_100_ok;
			res_duplex <= 1'b0;
		end
	end

	// partner ability register
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			partner <= '0;
		end else if (state != autoneg_pkg::ST_DISABLED
			&& state != autoneg_pkg::ST_BREAK && i_rx_word_valid) begin
			// base and next page words stored
			partner <= i_rx_word;
		end else if (state == autoneg_pkg::ST_ABILITY && pd_single) begin
			partner <= i_link_100_ok ? autoneg_pkg::PARTNER_PD_100
				: autoneg_pkg::PARTNER_PD_10;
		end
	end

	// expansion flags; a new event beats a clearing read
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pd_fault <= 1'b0;
			page_rx <= 1'b0;
			lp_np_able <= 1'b0;
			lp_an_able <= 1'b0;
		end else begin
			// sticky fault and page received flags
			if (state == autoneg_pkg::ST_ABILITY && pd_both) begin
				pd_fault <= 1'b1;
			end else if (rd_exp) begin
				pd_fault <= 1'b0;
			end
			if (state != autoneg_pkg::ST_DISABLED
				&& state != autoneg_pkg::ST_BREAK && i_rx_word_valid) begin
				page_rx <= 1'b1;
				lp_an_able <= 1'b1;
				lp_np_able <= i_rx_word[autoneg_pkg::CW_NEXT_PAGE_BIT];
			end else begin
				if (rd_exp) begin
					page_rx <= 1'b0;
				end
				if (next_state == autoneg_pkg::ST_BREAK) begin
					lp_an_able <= 1'b0;
					lp_np_able <= 1'b0;
				end
			end
		end
	end

	// link side outputs, all registered; tx word and quiet from next state
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_tx_word <= '0;
			o_tx_burst <= 1'b0;
			o_tx_quiet <= 1'b0;
			o_link_up <= 1'b0;
			o_speed_100 <= 1'b0;
			o_full_duplex <= 1'b0;
			o_an_complete <= 1'b0;
		end else begin
			// advertised word with ack once partner is heard
			o_tx_word <= {1'b0, next_state == autoneg_pkg::ST_ACK, 5'h00,
				adv, autoneg_pkg::SELECTOR_IEEE};
			// no burst on the edge that leaves for break or idle
			o_tx_burst <= ms_tick && wait_cnt == '0
				&& (state == autoneg_pkg::ST_ABILITY
				|| state == autoneg_pkg::ST_ACK)
				&& next_state != autoneg_pkg::ST_BREAK
				&& next_state != autoneg_pkg::ST_DISABLED;
			// no pulses or data during break link
			o_tx_quiet <= next_state == autoneg_pkg::ST_BREAK;
			o_link_up <= link_ok && (!neg_active
				|| state == autoneg_pkg::ST_GOOD);
			o_speed_100 <= op_speed;
			o_full_duplex <= op_duplex;
			o_an_complete <= state == autoneg_pkg::ST_GOOD;
		end
	end

	// read data selection
	always_comb begin
		next_rdata = '0;
		case (i_reg_addr)
			autoneg_pkg::REG_BASIC_MODE_CONTROL: begin
				next_rdata[autoneg_pkg::CTRL_SPEED_BIT] = ctrl_speed;
				next_rdata[autoneg_pkg::CTRL_NEG_ENABLE_BIT] = ctrl_neg_en;
				next_rdata[autoneg_pkg::CTRL_DUPLEX_BIT] = ctrl_duplex;
			end
			autoneg_pkg::REG_BASIC_MODE_STATUS: begin
				// live complete, fault and link bits
				next_rdata = autoneg_pkg::STATUS_FIXED;
				next_rdata[autoneg_pkg::STATUS_COMPLETE_BIT] = o_an_complete;
				next_rdata[autoneg_pkg::STATUS_REMOTE_FAULT_BIT] =
					partner[autoneg_pkg::CW_REMOTE_FAULT_BIT];
				next_rdata[autoneg_pkg::STATUS_LINK_BIT] = o_link_up;
			end
			autoneg_pkg::REG_NEGOTIATION_ADVERTISEMENT: begin
				next_rdata[autoneg_pkg::ADV_MSB:autoneg_pkg::ADV_LSB] = adv;
				next_rdata[4:0] = autoneg_pkg::SELECTOR_IEEE;
			end
			autoneg_pkg::REG_PARTNER_ABILITY: next_rdata = partner;
			autoneg_pkg::REG_NEGOTIATION_EXPANSION: begin
				next_rdata[autoneg_pkg::EXP_PD_FAULT_BIT] = pd_fault;
				next_rdata[autoneg_pkg::EXP_LP_NP_BIT] = lp_np_able;
				next_rdata[autoneg_pkg::EXP_NP_ABLE_BIT] = 1'b1;
				next_rdata[autoneg_pkg::EXP_PAGE_RX_BIT] = page_rx;
				next_rdata[autoneg_pkg::EXP_LP_AN_BIT] = lp_an_able;
			end
			autoneg_pkg::REG_PHY_LINK_STATUS: begin
				next_rdata[autoneg_pkg::PHYST_COMPLETE_BIT] = o_an_complete;
				next_rdata[autoneg_pkg::PHYST_DUPLEX_BIT] = o_full_duplex;
				next_rdata[autoneg_pkg::PHYST_SPEED10_BIT] = !o_speed_100;
				next_rdata[autoneg_pkg::PHYST_LINK_BIT] = o_link_up;
			end
			default: next_rdata = '0; // unmapped reads as zero
		endcase
	end

	// registered read port
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reg_rdata <= '0;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= next_rdata;
			end
		end
	end
endmodule

// *** test/autoneg_asserts.sv ***
/*
 * Checker for the negotiation block: read handshake, fixed register
 * fields, burst word layout, break link length and burst spacing.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module autoneg_asserts #(
	parameter int MS_TICK_CYCLES = 4,
	parameter int BREAK_LINK_MS = 3,
	parameter int BURST_INTERVAL_MS = 2
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_reg_rd,
	input wire logic [4:0] i_reg_addr,
	input wire logic [15:0] o_reg_rdata,
	input wire logic o_reg_rvalid,
	input wire logic [15:0] o_tx_word,
	input wire logic o_tx_burst,
	input wire logic o_tx_quiet,
	input wire logic o_link_up,
	input wire logic o_speed_100
);
	// one tick of slack either way for tick alignment
	localparam int QMIN = (BREAK_LINK_MS - 1) * MS_TICK_CYCLES;
	localparam int QMAX = (BREAK_LINK_MS + 1) * MS_TICK_CYCLES + 2;
	localparam int GMIN = (BURST_INTERVAL_MS - 1) * MS_TICK_CYCLES;
	int qcnt;
	int gap;

	// length of quiet stretch and distance between bursts
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			qcnt <= 0;
			gap <= 100000;
		end else begin
			qcnt <= o_tx_quiet ? qcnt + 1 : 0;
			gap <= o_tx_burst ? 1 : gap + 1;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	AST_RVALID: assert property (o_reg_rvalid == $past(i_reg_rd))
		else $error("read valid not one cycle after read");
	AST_STATUS: assert property ($past(i_reg_rd) &&
		$past(i_reg_addr) == 5'h01 |-> (o_reg_rdata & 16'hffcb) == 16'h7849)
		else $error("status constant bits wrong");
	AST_STATUS_LINK: assert property ($past(i_reg_rd) &&
		$past(i_reg_addr) == 5'h01 |-> o_reg_rdata[2] == $past(o_link_up))
		else $error("status link bit wrong");
	AST_ADV: assert property ($past(i_reg_rd) &&
		$past(i_reg_addr) == 5'h04 |->
		o_reg_rdata[4:0] == 5'h01 && o_reg_rdata[15:9] == 7'h00)
		else $error("advertisement fixed fields wrong");
	AST_EXP: assert property ($past(i_reg_rd) &&
		$past(i_reg_addr) == 5'h06 |-> o_reg_rdata[2] && !o_reg_rdata[15:5])
		else $error("expansion fixed fields wrong");
	AST_PHYST: assert property ($past(i_reg_rd) &&
		$past(i_reg_addr) == 5'h10 |->
		o_reg_rdata[1:0] == {!$past(o_speed_100), $past(o_link_up)})
		else $error("link status speed or link wrong");
	AST_BURST_WORD: assert property (o_tx_burst |->
		o_tx_word[4:0] == 5'h01 && o_tx_word[15] == 1'b0 &&
		o_tx_word[13:9] == 5'h00)
		else $error("burst word layout wrong");
	AST_QUIET_NO_BURST: assert property (o_tx_quiet |-> !o_tx_burst)
		else $error("burst during break link");
	AST_BREAK_MIN: assert property ($fell(o_tx_quiet) |-> qcnt >= QMIN)
		else $error("break link too short");
	AST_BREAK_MAX: assert property (qcnt <= QMAX)
		else $error("break link too long");
	AST_BURST_GAP: assert property (o_tx_burst |-> gap >= GMIN)
		else $error("bursts too close");
endmodule

bind autoneg_config_control autoneg_asserts #(
	.MS_TICK_CYCLES(MS_TICK_CYCLES),
	.BREAK_LINK_MS(BREAK_LINK_MS),
	.BURST_INTERVAL_MS(BURST_INTERVAL_MS)
) autoneg_asserts_i (.i_clk_sys, .i_rst_b, .i_reg_rd, .i_reg_addr,
	.o_reg_rdata, .o_reg_rvalid, .o_tx_word, .o_tx_burst, .o_tx_quiet,
	.o_link_up, .o_speed_100);

// *** test/link_partner_model.sv ***
/*
 * Remote link partner: answers bursts with its own code word, acks once
 * it heard a burst before, or shows a single steady link for parallel
 * detection. Assumes words are exchanged one per burst.
 */
`timescale 1ns/1ps
module link_partner_model (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [1:0] i_mode,
	input wire logic [3:0] i_abl,
	input wire logic i_burst,
	input wire logic [15:0] i_word,
	input wire logic i_quiet,
	output logic o_word_valid,
	output logic [15:0] o_word,
	output logic o_flp,
	output logic o_ok100,
	output logic o_ok10
);
	logic seen;
	logic linked;
	logic [3:0] cm;
	logic up100;

	// mode 0 silent, 1 negotiating, 2 steady 100, 3 steady 10
	assign cm = i_abl & i_word[8:5];
	assign up100 = cm[3] | cm[2];

	// reply per burst; idle word toggles so stale data never matches
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			seen <= 1'b0;
			linked <= 1'b0;
			o_word_valid <= 1'b0;
			o_word <= 16'h0000;
		end else begin
			o_word_valid <= i_burst && i_mode == 2'h1;
			if (i_burst && i_mode == 2'h1)
				o_word <= {1'b0, seen, 5'h00, i_abl, 5'h01};
			else
				o_word <= ~o_word;
			if (i_quiet || i_mode != 2'h1) begin
				seen <= 1'b0;
				linked <= 1'b0;
			end else if (i_burst) begin
				seen <= 1'b1;
				linked <= linked | (seen & i_word[14]);
			end
		end
	end

	// link lines follow the partner's own resolution
	always_comb begin
		o_flp = i_mode == 2'h1;
		o_ok100 = i_mode == 2'h2 || (linked && up100);
		o_ok10 = i_mode == 2'h3 || (linked && !up100 && |cm);
	end
endmodule

// *** test/testbench.sv ***
/*
 * Self-checking bench: strap capture, forced modes, negotiation with
 * random abilities, parallel detection and register reads.
 * Assumes shortened tick and break figures set at the instance.
 */
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst_b = 0, en = 0, s_hi = 0, s_lo = 0;
	logic wr = 0, rd = 0, rx_v, flp, ok100, ok10, rvalid, burst, quiet;
	logic link_up, spd, fdx, done;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000, rdata, tx_word, rx_word;
	logic [1:0] p_mode = 2'h0;
	logic [3:0] p_abl = 4'h0;
	logic [3:0] adv_tab [4] = '{4'h3, 4'hc, 4'h5, 4'hf};
	logic [31:0] seed = 32'h0000000a;
	logic [15:0] exp_q [$];
	int n_errors = 0, checked = 0, cycles = 0;

	always #2 clk = ~clk;

	autoneg_config_control #(.MS_TICK_CYCLES(4), .BREAK_LINK_MS(3),
		.BURST_INTERVAL_MS(2)) autoneg_config_control_i (
		.i_clk_sys(clk), .i_rst_b(rst_b), .i_negotiate_enable_strap(en),
		.i_mode_strap_high(s_hi), .i_mode_strap_low(s_lo),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_rx_word_valid(rx_v), .i_rx_word(rx_word),
		.i_flp_seen(flp), .i_link_100_ok(ok100), .i_link_10_ok(ok10),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_tx_word(tx_word),
		.o_tx_burst(burst), .o_tx_quiet(quiet), .o_link_up(link_up),
		.o_speed_100(spd), .o_full_duplex(fdx), .o_an_complete(done));

	link_partner_model link_partner_model_i (.i_clk(clk), .i_rst_b(rst_b),
		.i_mode(p_mode), .i_abl(p_abl), .i_burst(burst), .i_word(tx_word),
		.i_quiet(quiet), .o_word_valid(rx_v), .o_word(rx_word),
		.o_flp(flp), .o_ok100(ok100), .o_ok10(ok10));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (n_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk);
		wr = 1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 0;
	endtask

	// expected value queued before the strobe edge
	task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
		@(negedge clk);
		rd = 1;
		addr = a;
		exp_q.push_back(e);
		@(negedge clk);
		rd = 0;
	endtask

	task automatic do_reset(input logic [2:0] s);
		@(negedge clk);
		rst_b = 0;
		{en, s_hi, s_lo} = s;
		repeat (4) @(negedge clk);
		rst_b = 1;
		repeat (3) @(negedge clk);
	endtask

	// bounded wait, the break and exchange take a few dozen cycles
	task automatic restart(input logic [15:0] c);
		wr_reg(5'h00, c);
		repeat (2) @(negedge clk);
		check("quiet", quiet, 1);
		for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
		check("complete", done, 1);
	endtask

	// read results compared in arrival order
	always @(posedge clk) begin
		if (rvalid === 1'b1)
			check("rdata", rdata, exp_q.size() ? exp_q.pop_front() : 'x);
	end

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	initial begin
		logic [3:0] adv, pa, cm;
		logic [15:0] ctl;
		for (int s = 0; s < 8; s++) begin
			do_reset(s[2:0]);
			adv = s[2] ? adv_tab[s[1:0]] : 4'h1 << s[1:0];
			rd_reg(5'h04, {7'h00, adv, 5'h01});
			rd_reg(5'h00, {2'h0, s[1], s[2], 3'h0, s[0], 8'h00});
			if (!s[2]) begin
				check("spd", spd, s[1]);
				check("fdx", fdx, s[0]);
			end
		end
		do_reset(3'b011);
		p_mode = 2'h1;
		wr_reg(5'h00, 16'h1200);
		repeat (3) @(negedge clk);
		check("quiet", quiet, 0);
		wr_reg(5'h00, 16'h0000);
		repeat (2) @(negedge clk);
		check("spd", spd, 0);
		wr_reg(5'h00, 16'h2100);
		repeat (2) @(negedge clk);
		check("fdx", fdx, 1);
		rd_reg(5'h1f, 16'h0000);
		for (int k = 0; k < 6; k++) begin
			seed = xs(seed);
			adv = seed[3:0] == 4'h0 ? 4'h9 : seed[3:0];
			pa = seed[7:4] | (adv & -adv);
			cm = adv & pa;
			p_abl = pa;
			wr_reg(5'h04, {7'h00, adv, 5'h01});
			ctl = {2'h0, seed[9], 1'b1, 2'h0, 1'b1, seed[8], 8'h00};
			restart(ctl);
			check("spd", spd, cm[3] | cm[2]);
			check("fdx", fdx, cm[3] | (!cm[2] & cm[1]));
			rd_reg(5'h05, {2'b01, 5'h00, pa, 5'h01});
			rd_reg(5'h10, {11'h000, 2'b10, cm[3] | (!cm[2] & cm[1]),
				!(cm[3] | cm[2]), 1'b1});
			rd_reg(5'h01, 16'h786d);
			rd_reg(5'h06, 16'h0007);
		end
		p_mode = 2'h2;
		restart(16'h1200);
		check("spd", spd, 1);
		wr_reg(5'h05, 16'hffff);
		rd_reg(5'h05, 16'h0081);
		p_mode = 2'h3;
		restart(16'h1200);
		check("spd", spd, 0);
		rd_reg(5'h05, 16'h0021);
		repeat (4) @(negedge clk);
		tally_and_finish();
	end
endmodule
